// ===== rtl/dii_top.sv
// Drive interlock input monitor: synchronises, debounces and decodes the field contacts.
// Assumes contacts and settings arrive synchronous to clk_i; settings are static levels.
//
// How it works
// - An active second external fault opens the main contactor, an inactive one does nothing.
// - The transfer start input starts a synchronous transfer only while the grid transfer permit is set.
// - The excitation ready input reports whether the exciter is ready to begin excitation.
// - The excitation running input reports whether the exciter field is in operation.
// - The excitation fault input reports an exciter field fault while active.
// - A fan breaker chain that goes inactive raises the fan failure alarm.
// - The fans running input reports all fan contactor auxiliaries closed while active.
// - The cell door input reports all cell doors closed and locked while active.
// - With fault reaction, an open cell door raises a cell door fault and switches the drive off.
// - With alarm reaction, an open cell door raises only a cell door alarm and the drive keeps running.
// - The transformer door input reports all transformer doors closed and locked while active.
// - An open transformer door gives a fault and switch off, or an alarm only, by the reaction setting.
`timescale 1ns/100ps
`include "dii_defines.svh"

module dii_top #(
    parameter int unsigned DEBOUNCE_CYC = `DII_DEBOUNCE_CYC,
    parameter int unsigned N_IN         = `DII_IN_NUM
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire dii_pkg::dii_contacts_t contacts_i,
    input  wire logic                   grid_transfer_permit_i,
    input  wire logic                   door_react_fault_i,
    output dii_pkg::dii_status_t        status_o
);
    import dii_pkg::*;

    localparam int unsigned CNT_W = $clog2(DEBOUNCE_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE_CYC - 1);

    logic [N_IN-1:0]  raw;
    logic [N_IN-1:0]  sync1_reg;
    logic [N_IN-1:0]  sync2_reg;
    logic [N_IN-1:0]  filt_reg;
    logic [CNT_W-1:0] cnt_reg [N_IN];
    dii_status_t      status_reg;
    dii_status_t      status_next;
    logic             armed_reg;

    // Counts cycles in which the synchronised level disagrees with the filtered one.
    function automatic logic [CNT_W-1:0] cnt_step(input logic differ, input logic [CNT_W-1:0] cnt);
        if (!differ || cnt == CNT_LAST)
        begin
            return '0;
        end
        return cnt + CNT_W'(1);
    endfunction

    assign raw = contacts_i;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sync1_reg <= `DII_FILT_RST;
            sync2_reg <= `DII_FILT_RST;
        end
        else
        begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
        end
    end

    // A level is taken only after it has differed for DEBOUNCE_CYC consecutive cycles.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            filt_reg <= `DII_FILT_RST;
            for (int i = 0; i < N_IN; i++)
            begin
                cnt_reg[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < N_IN; i++)
            begin
                cnt_reg[i] <= cnt_step(sync2_reg[i] != filt_reg[i], cnt_reg[i]);
                if (sync2_reg[i] != filt_reg[i] && cnt_reg[i] == CNT_LAST)
                begin
                    filt_reg[i] <= sync2_reg[i];
                end
            end
        end
    end

    always_comb
    begin
        status_next = '0;
        status_next.main_contactor_open = filt_reg[`DII_IN_EXT_FAULT2];
        status_next.transfer_start = filt_reg[`DII_IN_SYNC_XFER] & grid_transfer_permit_i;
        status_next.exc_ready = filt_reg[`DII_IN_EXC_READY];
        status_next.exc_running = filt_reg[`DII_IN_EXC_ON];
        status_next.exc_fault = filt_reg[`DII_IN_EXC_FAULT];
        status_next.fan_fail_alarm = ~filt_reg[`DII_IN_FAN_CB_OK];
        status_next.fans_running = filt_reg[`DII_IN_FANS_ON];
        status_next.cell_door_closed = filt_reg[`DII_IN_CELL_DOOR];
        status_next.trafo_door_closed = filt_reg[`DII_IN_TRAFO_DOOR];
        status_next.cell_door_fault = ~filt_reg[`DII_IN_CELL_DOOR] & door_react_fault_i;
        status_next.cell_door_alarm = ~filt_reg[`DII_IN_CELL_DOOR] & ~door_react_fault_i;
        status_next.trafo_door_fault = ~filt_reg[`DII_IN_TRAFO_DOOR] & door_react_fault_i;
        status_next.trafo_door_alarm = ~filt_reg[`DII_IN_TRAFO_DOOR] & ~door_react_fault_i;
        // An alarm-only door reaction never contributes to switching off.
        status_next.drive_off = status_next.main_contactor_open | status_next.cell_door_fault
                              | status_next.trafo_door_fault;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            status_reg <= `DII_STATUS_RST;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    assign status_o = status_reg;

    // Keeps the checks off until status_o shows filtered levels again after a reset.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            armed_reg <= 1'b0;
        end
        else
        begin
            armed_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i || !armed_reg);

    a_ext_fault_trip: assert property (
        filt_reg[`DII_IN_EXT_FAULT2] |=> status_o.main_contactor_open && status_o.drive_off)
        else $error("External fault did not open the main contactor.");

    a_xfer_permit_gate: assert property (
        ##1 status_o.transfer_start |-> $past(grid_transfer_permit_i) && $past(filt_reg[`DII_IN_SYNC_XFER]))
        else $error("Transfer start raised without permit or input.");

    a_exc_status_map: assert property (
        ##1 {status_o.exc_ready, status_o.exc_running, status_o.exc_fault}
            == $past(filt_reg[`DII_IN_EXC_READY:`DII_IN_EXC_FAULT]))
        else $error("Excitation status does not follow its inputs.");

    a_exc_fault_rep: assert property (
        $rose(filt_reg[`DII_IN_EXC_FAULT]) |=> status_o.exc_fault)
        else $error("Exciter fault not reported.");

    a_fan_fail_alarm: assert property (
        $fell(filt_reg[`DII_IN_FAN_CB_OK]) |=> status_o.fan_fail_alarm)
        else $error("Fan failure alarm not raised.");

    a_fans_running_map: assert property (
        ##1 status_o.fans_running == $past(filt_reg[`DII_IN_FANS_ON]))
        else $error("Fans running indication wrong.");

    a_cell_door_react: assert property (
        !filt_reg[`DII_IN_CELL_DOOR] && door_react_fault_i
            |=> status_o.cell_door_fault && !status_o.cell_door_alarm && status_o.drive_off)
        else $error("Cell door fault reaction wrong.");

    a_cell_door_alarm: assert property (
        !filt_reg[`DII_IN_CELL_DOOR] && !door_react_fault_i && !filt_reg[`DII_IN_EXT_FAULT2]
            && filt_reg[`DII_IN_TRAFO_DOOR]
            |=> status_o.cell_door_alarm && !status_o.cell_door_fault && !status_o.drive_off)
        else $error("Cell door alarm reaction wrong.");

    a_trafo_door_react: assert property (
        !filt_reg[`DII_IN_TRAFO_DOOR]
            |=> (status_o.trafo_door_fault == $past(door_react_fault_i))
                && (status_o.trafo_door_alarm == !$past(door_react_fault_i)))
        else $error("Transformer door reaction wrong.");

    a_door_closed_map: assert property (
        ##1 {status_o.cell_door_closed, status_o.trafo_door_closed}
            == $past(filt_reg[`DII_IN_CELL_DOOR:`DII_IN_TRAFO_DOOR]))
        else $error("Door closed indication wrong.");

    a_filter_stable: assert property (
        $changed(filt_reg) |-> $past(sync2_reg != filt_reg))
        else $error("Filtered level changed without a differing input.");

    a_bounce_reject: assert property (
        $changed(sync2_reg[`DII_IN_EXT_FAULT2]) && DEBOUNCE_CYC > 1 |=> $stable(filt_reg[`DII_IN_EXT_FAULT2]))
        else $error("Bounce passed the filter.");

    a_ext_fault_idle: assert property (
        !filt_reg[`DII_IN_EXT_FAULT2] |=> !status_o.main_contactor_open)
        else $error("Main contactor opened without external fault.");

    a_xfer_start_level: assert property (
        filt_reg[`DII_IN_SYNC_XFER] && grid_transfer_permit_i |=> status_o.transfer_start)
        else $error("Transfer start missing with permit and input.");

    a_fan_alarm_level: assert property (
        ##1 status_o.fan_fail_alarm == !$past(filt_reg[`DII_IN_FAN_CB_OK]))
        else $error("Fan failure alarm does not follow the breaker chain.");

    a_drive_off_map: assert property (
        ##1 status_o.drive_off == ($past(filt_reg[`DII_IN_EXT_FAULT2])
            || ($past(door_react_fault_i) && !$past(filt_reg[`DII_IN_CELL_DOOR]))
            || ($past(door_react_fault_i) && !$past(filt_reg[`DII_IN_TRAFO_DOOR]))))
        else $error("Drive off does not follow trips and door faults.");

    a_count_restart: assert property (
        sync2_reg[`DII_IN_EXT_FAULT2] == filt_reg[`DII_IN_EXT_FAULT2] |=> cnt_reg[`DII_IN_EXT_FAULT2] == '0)
        else $error("Debounce count did not restart on an agreeing sample.");

    c_ext_trip: cover property ($rose(status_o.main_contactor_open));
    c_fan_alarm: cover property ($rose(status_o.fan_fail_alarm));
    c_xfer_start: cover property ($rose(status_o.transfer_start));
    c_cell_fault: cover property ($rose(status_o.cell_door_fault));
    c_trafo_alarm: cover property ($rose(status_o.trafo_door_alarm));

endmodule

// ===== rtl/dii_defines.svh
// Constants for the drive interlock input monitor: bit positions, timing and reset values.
// Assumes inclusion by bare name from the design files only.
`ifndef DII_DEFINES_SVH
`define DII_DEFINES_SVH

`define DII_CLK_MHZ         10
`define DII_DEBOUNCE_US     20000
`define DII_DEBOUNCE_CYC    (`DII_DEBOUNCE_US * `DII_CLK_MHZ)

`define DII_IN_NUM          9
`define DII_IN_TRAFO_DOOR   0
`define DII_IN_CELL_DOOR    1
`define DII_IN_FANS_ON      2
`define DII_IN_FAN_CB_OK    3
`define DII_IN_EXC_FAULT    4
`define DII_IN_EXC_ON       5
`define DII_IN_EXC_READY    6
`define DII_IN_SYNC_XFER    7
`define DII_IN_EXT_FAULT2   8

`define DII_FILT_RST        9'h000
`define DII_STATUS_RST      14'h0000

`endif

// ===== rtl/dii_pkg.sv
// Types shared by the drive interlock input monitor.
// Assumes the member order matches the bit positions in dii_defines.svh.
package dii_pkg;

    // One bit per field contact, 1 = contact closed.
    typedef struct packed {
        logic ext_fault2;
        logic sync_xfer;
        logic exc_ready;
        logic exc_on;
        logic exc_fault;
        logic fan_cb_ok;
        logic fans_on;
        logic cell_door;
        logic trafo_door;
    } dii_contacts_t;

    // Indications derived from the filtered contacts.
    typedef struct packed {
        logic main_contactor_open;
        logic transfer_start;
        logic exc_ready;
        logic exc_running;
        logic exc_fault;
        logic fan_fail_alarm;
        logic fans_running;
        logic cell_door_closed;
        logic trafo_door_closed;
        logic cell_door_fault;
        logic cell_door_alarm;
        logic trafo_door_fault;
        logic trafo_door_alarm;
        logic drive_off;
    } dii_status_t;

endpackage

// ===== test/dii_field.sv
// Field contact model: drives the contact levels, with optional chatter.
// Assumes clk_i is the system clock of the monitor.
`timescale 1ns/100ps
module dii_field (
    input  wire logic                   clk_i,
    input  wire dii_pkg::dii_contacts_t target_i,
    input  wire logic                   bounce_i,
    output dii_pkg::dii_contacts_t      contacts_o
);
    import dii_pkg::*;
    logic toggle_reg = 1'b0;
    // Chatter flips every contact each cycle, so no level ever settles.
    always @(posedge clk_i)
    begin
        toggle_reg <= ~toggle_reg;
        contacts_o <= bounce_i ? (target_i ^ {9{toggle_reg}}) : target_i;
    end
endmodule

// ===== test/dii_top_test.sv
// Self-checking bench for the drive interlock input monitor.
// Assumes a short debounce parameter and the field model in dii_field.sv.
`timescale 1ns/100ps
module dii_top_test;
    import dii_pkg::*;
    localparam int unsigned DEB = 4;
    logic          clk_i = 1'b0;
    logic          rst_n_i = 1'b0;
    logic          permit = 1'b0;
    logic          react = 1'b1;
    logic          bounce = 1'b0;
    dii_contacts_t target = '0;
    dii_contacts_t contacts;
    dii_status_t   status;
    dii_status_t   held;
    int            fail_count = 0;
    int            check_count = 0;
    always #50 clk_i = ~clk_i;
    dii_field field (.clk_i(clk_i), .target_i(target), .bounce_i(bounce), .contacts_o(contacts));
    dii_top #(.DEBOUNCE_CYC(DEB)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .contacts_i(contacts),
        .grid_transfer_permit_i(permit), .door_react_fault_i(react), .status_o(status));
    function automatic dii_status_t model(dii_contacts_t c, logic p, logic r);
        dii_status_t s;
        s.main_contactor_open = c.ext_fault2;
        s.transfer_start      = c.sync_xfer & p;
        s.exc_ready           = c.exc_ready;
        s.exc_running         = c.exc_on;
        s.exc_fault           = c.exc_fault;
        s.fan_fail_alarm      = ~c.fan_cb_ok;
        s.fans_running        = c.fans_on;
        s.cell_door_closed    = c.cell_door;
        s.trafo_door_closed   = c.trafo_door;
        s.cell_door_fault     = ~c.cell_door & r;
        s.cell_door_alarm     = ~c.cell_door & ~r;
        s.trafo_door_fault    = ~c.trafo_door & r;
        s.trafo_door_alarm    = ~c.trafo_door & ~r;
        s.drive_off = c.ext_fault2 | s.cell_door_fault | s.trafo_door_fault;
        return s;
    endfunction
    task automatic check(dii_status_t seen, dii_status_t want);
        check_count++;
        if (seen !== want)
        begin
            fail_count++;
            $display("BAD %0t status %h expected %h", $time, seen, want);
        end
    endtask
    task automatic apply(dii_contacts_t c, logic p, logic r);
        @(posedge clk_i);
        target <= c;
        permit <= p;
        react  <= r;
        repeat (DEB + 5) @(posedge clk_i);
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #2000000;
        fail_count++;
        final_report();
    end
    initial
    begin
        void'($urandom(32'h393dd9b3));
        repeat (4) @(posedge clk_i);
        #1 check(status, '0);
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (DEB + 6) @(posedge clk_i);
        #1 check(status, model('0, 1'b0, 1'b1));
        $display("test reset done");
        @(posedge clk_i);
        target <= '1;
        repeat (DEB + 3) @(posedge clk_i);
        #1 check(status, model('0, 1'b0, 1'b1));
        @(posedge clk_i);
        #1 check(status, model('1, 1'b0, 1'b1));
        $display("test latency done");
        for (int i = 0; i < 9; i++)
        begin
            apply(9'h001 << i, i[0], i[1]);
            check(status, model(9'h001 << i, i[0], i[1]));
            apply(~(9'h001 << i), i[1], i[0]);
            check(status, model(~(9'h001 << i), i[1], i[0]));
        end
        $display("test single inputs done");
        for (int i = 0; i < 16; i++)
        begin
            apply(dii_contacts_t'(9'($urandom)), 1'($urandom), 1'($urandom));
            check(status, model(target, permit, react));
        end
        $display("test random done");
        held = status;
        @(posedge clk_i);
        bounce <= 1'b1;
        repeat (DEB * 4) @(posedge clk_i);
        #1 check(status, held);
        @(posedge clk_i);
        bounce <= 1'b0;
        apply(target, permit, react);
        check(status, held);
        $display("test chatter done");
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1 check(status, '0);
        @(posedge clk_i);
        #1 check(status, model('0, permit, react));
        repeat (DEB + 1) @(posedge clk_i);
        #1 check(status, model('0, permit, react));
        @(posedge clk_i);
        #1 check(status, model(target, permit, react));
        $display("test mid-run reset done");
        final_report();
    end
endmodule
